// file: rtl/ibm_command.sv
// Top: bus-master I/O window decode, two channels and drive timing select
`timescale 1ns/10ps
module ibm_command
	import ibm_pkg::*;
#(
	parameter int ABITS = 16
)(
	input  wire logic             CLOCK,
	input  wire logic             SRST,
	input  wire logic [ABITS-1:0] BASE_ADDR,
	input  wire logic             IO_SEL,
	input  wire logic             IO_WR,
	input  wire logic [ABITS-1:0] IO_ADDR,
	input  wire logic [3:0]       IO_BE,
	input  wire logic [31:0]      IO_WDATA,
	input  wire logic [1:0]       EOT_DONE,
	input  wire logic [1:0]       SYNC_DMA,
	input  wire logic [1:0]       DRIVE_IRQ,
	input  wire logic [1:0]       DMA_CYCLE,
	input  wire logic [1:0]       DMA_ONLY_TIMING_ENABLE,
	input  wire ibm_mode_t        FAST_MODE_0,
	input  wire ibm_mode_t        FAST_MODE_1,
	output logic      [31:0]      IO_RDATA,
	output logic                  IO_HIT,
	output logic      [1:0]       GO,
	output logic      [1:0]       DIRECTION,
	output logic      [1:0]       ACTIVE,
	output logic      [1:0]       ABORT,
	output logic      [1:0]       IRQ_STATUS,
	output ibm_timing_t           TIMING_0,
	output ibm_timing_t           TIMING_1
);

	logic        hit;
	logic [3:0]  ofs;
	logic [7:0]  cmd_rd     [2];
	ibm_chan_t   chan       [2];
	logic [1:0]  irq_st;
	logic [31:0] word_ch    [2];
	logic [31:0] word_sel;
	logic [31:0] lane_mask;
	logic [31:0] rdata_r,   rdata_nxt;
	logic        hit_r,     hit_nxt;
	// Port copies of the channel controls
	logic [1:0]  go_r,      go_nxt;
	logic [1:0]  dir_r,     dir_nxt;
	logic [1:0]  act_r,     act_nxt;
	logic [1:0]  abort_r,   abort_nxt;
	logic [1:0]  irq_q_r,   irq_q_nxt;
	ibm_timing_t tim_r [2], tim_nxt [2];

	// window decode
	// Base bits below 4 are ignored, so the window is always 16-byte aligned
	assign hit = IO_SEL && (IO_ADDR[ABITS-1:4] == BASE_ADDR[ABITS-1:4]);
	// Dword granularity: byte lanes pick the bytes inside the word
	assign ofs = {IO_ADDR[3:2], 2'b00};

	function automatic ibm_timing_t mode_tim(input ibm_mode_t m);
		ibm_timing_t t;
		case (m)
			IBM_MODE_PIO0: t = '{IBM_ISP_PIO0, IBM_RCT_PIO0};
			IBM_MODE_PIO2: t = '{IBM_ISP_PIO2, IBM_RCT_PIO2};
			IBM_MODE_PIO3: t = '{IBM_ISP_PIO3, IBM_RCT_PIO3};
			IBM_MODE_PIO4: t = '{IBM_ISP_PIO4, IBM_RCT_PIO4};
			default:       t = '{IBM_ISP_PIO0, IBM_RCT_PIO0};
		endcase
		return t;
	endfunction : mode_tim

	// Per-channel decode, command register and drive timing
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic       wr;
			logic       clr;
			logic [3:0] base;
			logic [7:0] stat_byte;
			assign base = g ? IBM_OFS_SEC_CMD : IBM_OFS_PRI_CMD;
			assign wr  = hit && IO_WR && (ofs == base) && IO_BE[0];
			// Writing one to status bit 2 clears the interrupt flag
			assign clr = hit && IO_WR && (ofs == base) && IO_BE[2]
			             && IO_WDATA[18];

			ibm_channel u_ch (
				.clk        (CLOCK),
				.srst       (SRST),
				.wr_en      (wr),
				.wr_data    (IO_WDATA[7:0] & IBM_CMD_WMASK),
				.eot_done   (EOT_DONE[g]),
				.sync_dma   (SYNC_DMA[g]),
				.drive_irq  (DRIVE_IRQ[g]),
				.irq_clear  (clr),
				.cmd_rd     (cmd_rd[g]),
				.chan       (chan[g]),
				.irq_status (irq_st[g])
			);

			// Status byte rides in lane 2: bit 2 interrupt, bit 0 active
			assign stat_byte  = {5'h00, irq_st[g], 1'b0, chan[g].active};
			assign word_ch[g] = {8'h00, stat_byte, 8'h00, cmd_rd[g]};

			always_comb begin
				// fast timing DMA only
				// PIO cycles fall back to compatible timing
				if (DMA_ONLY_TIMING_ENABLE[g] && !DMA_CYCLE[g])
					tim_nxt[g] = mode_tim(IBM_MODE_PIO0);
				else
					tim_nxt[g] = mode_tim(g ? FAST_MODE_1 : FAST_MODE_0);
			end
		end
	endgenerate

	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_lane
			// only enabled byte lanes carry data
			// Reads have no side effects, so disabled lanes just read zero
			assign lane_mask[8*b +: 8] = {8{IO_BE[b]}};
		end
	endgenerate

	// Read path: the answer is registered, one clock after the request
	always_comb begin
		hit_nxt   = hit && !IO_WR;
		rdata_nxt = 32'h0000_0000;
		word_sel  = 32'h0000_0000;
		// command words at 00h and 08h
		case (ofs)
			IBM_OFS_PRI_CMD: word_sel = word_ch[0];
			IBM_OFS_SEC_CMD: word_sel = word_ch[1];
			default:         word_sel = 32'h0000_0000;
		endcase
		if (hit && !IO_WR)
			rdata_nxt = word_sel & lane_mask;
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			rdata_r <= 32'h0000_0000;
			hit_r   <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			hit_r   <= hit_nxt;
		end
	end

	// Channel controls pass one more stage so every port leaves a flop
	// Command bits and flags therefore appear two clocks after the write
	always_comb begin
		go_nxt    = {chan[1].go, chan[0].go};
		dir_nxt   = {chan[1].dir, chan[0].dir};
		act_nxt   = {chan[1].active, chan[0].active};
		abort_nxt = {chan[1].abort, chan[0].abort};
		irq_q_nxt = irq_st;
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			go_r    <= 2'b00;
			dir_r   <= 2'b00;
			act_r   <= 2'b00;
			abort_r <= 2'b00;
			irq_q_r <= 2'b00;
		end else begin
			go_r    <= go_nxt;
			dir_r   <= dir_nxt;
			act_r   <= act_nxt;
			abort_r <= abort_nxt;
			irq_q_r <= irq_q_nxt;
		end
	end

	// compatible timing while reset is held, mode select from the first clock after
	// Timing follows the mode select one clock later
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			tim_r[0] <= '{IBM_ISP_PIO0, IBM_RCT_PIO0};
			tim_r[1] <= '{IBM_ISP_PIO0, IBM_RCT_PIO0};
		end else begin
			tim_r[0] <= tim_nxt[0];
			tim_r[1] <= tim_nxt[1];
		end
	end

	assign IO_RDATA   = rdata_r;
	assign IO_HIT     = hit_r;
	assign GO         = go_r;
	assign DIRECTION  = dir_r;
	assign ACTIVE     = act_r;
	assign ABORT      = abort_r;
	assign IRQ_STATUS = irq_q_r;
	assign TIMING_0   = tim_r[0];
	assign TIMING_1   = tim_r[1];

endmodule : ibm_command

// file: inc/ibm_pkg.sv
// Package: constants and types for the bus-master command front end
package ibm_pkg;

	localparam int          IBM_WINDOW_BYTES  = 16;
	localparam logic [3:0]  IBM_OFS_PRI_CMD   = 4'h0;
	localparam logic [3:0]  IBM_OFS_SEC_CMD   = 4'h8;
	localparam logic [7:0]  IBM_CMD_RESET     = 8'h00;
	localparam int          IBM_BIT_GO        = 0;
	localparam int          IBM_BIT_DIR       = 3;
	localparam logic [7:0]  IBM_CMD_WMASK     = 8'h09;

	// Recommended drive timing (clocks) per mode
	localparam logic [2:0]  IBM_ISP_PIO0      = 3'h5;
	localparam logic [2:0]  IBM_RCT_PIO0      = 3'h4;
	localparam logic [2:0]  IBM_ISP_PIO2      = 3'h4;
	localparam logic [2:0]  IBM_RCT_PIO2      = 3'h4;
	localparam logic [2:0]  IBM_ISP_PIO3      = 3'h3;
	localparam logic [2:0]  IBM_RCT_PIO3      = 3'h3;
	localparam logic [2:0]  IBM_ISP_PIO4      = 3'h3;
	localparam logic [2:0]  IBM_RCT_PIO4      = 3'h1;

	typedef enum logic [1:0] {
		IBM_MODE_PIO0,
		IBM_MODE_PIO2,
		IBM_MODE_PIO3,
		IBM_MODE_PIO4
	} ibm_mode_t;

	typedef struct packed {
		logic [2:0] ready_sample_point;
		logic [2:0] recovery_clocks;
	} ibm_timing_t;

	typedef enum {
		IBM_IDLE,
		IBM_ACTIVE,
		IBM_DONE
	} ibm_state_t;

	typedef struct packed {
		logic       go;
		logic       dir;
		logic       active;
		logic       abort;
	} ibm_chan_t;

endpackage : ibm_pkg

// file: rtl/ibm_channel.sv
// Per-channel command register and transfer control
`timescale 1ns/10ps
module ibm_channel
	import ibm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_data,
	input  wire logic        eot_done,
	input  wire logic        sync_dma,
	input  wire logic        drive_irq,
	input  wire logic        irq_clear,
	output logic      [7:0]  cmd_rd,
	output ibm_chan_t        chan,
	output logic             irq_status
);

	ibm_state_t  state_r,  state_nxt;
	logic        go_r,     go_nxt;
	logic        dir_r,    dir_nxt;
	logic        abort_r,  abort_nxt;
	logic        irq_r,    irq_nxt;
	logic        irq_d_r,  irq_d_nxt;

	always_comb begin
		state_nxt = state_r;
		go_nxt    = go_r;
		dir_nxt   = dir_r;
		abort_nxt = 1'b0;
		irq_d_nxt = drive_irq;
		irq_nxt   = irq_r;
		if (irq_clear)
			irq_nxt = 1'b0;
		if (drive_irq && !irq_d_r)
			irq_nxt = 1'b1;
		if (wr_en) begin
			if (!(sync_dma && state_r == IBM_ACTIVE))
				dir_nxt = wr_data[IBM_BIT_DIR];
			go_nxt = wr_data[IBM_BIT_GO];
		end
		case (state_r)
			IBM_IDLE: begin
				if (wr_en && wr_data[IBM_BIT_GO] && !go_r)
					state_nxt = IBM_ACTIVE;
			end
			IBM_ACTIVE: begin
				if (wr_en && !wr_data[IBM_BIT_GO]) begin
					state_nxt = IBM_IDLE;
					abort_nxt = !irq_r;
				end else if (eot_done)
					state_nxt = IBM_DONE;
			end
			IBM_DONE: begin
				if (wr_en && !wr_data[IBM_BIT_GO])
					state_nxt = IBM_IDLE;
			end
			default: state_nxt = IBM_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= IBM_IDLE;
			go_r    <= IBM_CMD_RESET[IBM_BIT_GO];
			dir_r   <= IBM_CMD_RESET[IBM_BIT_DIR];
			abort_r <= 1'b0;
			irq_r   <= 1'b0;
			irq_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			go_r    <= go_nxt;
			dir_r   <= dir_nxt;
			abort_r <= abort_nxt;
			irq_r   <= irq_nxt;
			irq_d_r <= irq_d_nxt;
		end
	end

	assign cmd_rd      = {4'h0, dir_r, 2'b00, go_r};
	assign chan.go     = go_r && (state_r == IBM_ACTIVE);
	assign chan.dir    = dir_r;
	assign chan.active = (state_r == IBM_ACTIVE);
	assign chan.abort  = abort_r;
	assign irq_status  = irq_r;

endmodule : ibm_channel

// file: verif/ibm_drive_model.sv
// Drive model: raises its interrupt some cycles after bus-master start
`timescale 1ns/10ps
module ibm_drive_model #(
	parameter int DELAY = 20
)(
	input  wire logic	clk,
	input  wire logic [1:0]	go,
	output logic [1:0]	irq = 2'h0
);
	int	cnt [2] = '{0, 0};
	// Slow on purpose, so an early stop meets a drive still mid-transfer
	always @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			cnt[i] <= go[i] ? cnt[i] + 1 : 0;
			irq[i] <= go[i] && cnt[i] >= DELAY;
		end
	end
endmodule : ibm_drive_model

// file: verif/ibm_command_assertions.sv
// Checker: port-level properties of the command front end
`timescale 1ns/10ps
module ibm_command_assertions #(
	parameter int ABITS = 16
)(
	input wire logic	CLOCK,
	input wire logic	SRST,
	input wire logic [ABITS-1:0]	BASE_ADDR,
	input wire logic	IO_SEL,
	input wire logic	IO_WR,
	input wire logic [ABITS-1:0]	IO_ADDR,
	input wire logic [3:0]	IO_BE,
	input wire logic [31:0]	IO_WDATA,
	input wire logic [1:0]	SYNC_DMA,
	input wire logic [1:0]	DRIVE_IRQ,
	input wire logic [31:0]	IO_RDATA,
	input wire logic	IO_HIT,
	input wire logic [1:0]	GO,
	input wire logic [1:0]	DIRECTION,
	input wire logic [1:0]	ACTIVE,
	input wire logic [1:0]	ABORT,
	input wire logic [1:0]	IRQ_STATUS
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SRST);
	wire logic	hit = IO_ADDR[ABITS-1:4] == BASE_ADDR[ABITS-1:4];
	wire logic	cmd0 = IO_SEL && IO_WR && hit && IO_ADDR[3:0] == 4'h0 && IO_BE[0];
	sequence s_on;
		##2 GO[0] && ACTIVE[0];
	endsequence
	sequence s_off;
		##2 !GO[0] && !ACTIVE[0];
	endsequence
	chk_go_start: assert property (cmd0 && IO_WDATA[0] |-> s_on)
		else $error("start write did not raise go and active");
	chk_go_stop: assert property (cmd0 && !IO_WDATA[0] |-> s_off)
		else $error("stop write did not clear go and active");
	chk_abort_pulse: assert property (ABORT[0] |-> !GO[0] ##1 !ABORT[0])
		else $error("abort pulse malformed");
	chk_read_hit: assert property (IO_SEL && !IO_WR && hit |=> IO_HIT)
		else $error("read inside window not answered");
	chk_read_miss: assert property (IO_SEL && !hit |=> !IO_HIT)
		else $error("access outside window answered");
	chk_reserved_zero: assert property (IO_HIT |-> IO_RDATA[7:4] == 4'h0 && IO_RDATA[2:1] == 2'h0)
		else $error("reserved command bits not zero");
	chk_dir_locked: assert property ($past(SYNC_DMA[0], 2) && $past(ACTIVE[0]) |-> $stable(DIRECTION[0]))
		else $error("direction changed during synchronous transfer");
	chk_irq_edge: assert property ($rose(DRIVE_IRQ[0]) |-> ##2 IRQ_STATUS[0])
		else $error("interrupt edge not captured");
endmodule : ibm_command_assertions

bind ibm_command ibm_command_assertions #(.ABITS(ABITS)) ibm_command_assertions_inst (
	.CLOCK(CLOCK), .SRST(SRST), .BASE_ADDR(BASE_ADDR), .IO_SEL(IO_SEL), .IO_WR(IO_WR),
	.IO_ADDR(IO_ADDR), .IO_BE(IO_BE), .IO_WDATA(IO_WDATA), .SYNC_DMA(SYNC_DMA),
	.DRIVE_IRQ(DRIVE_IRQ), .IO_RDATA(IO_RDATA), .IO_HIT(IO_HIT), .GO(GO),
	.DIRECTION(DIRECTION), .ACTIVE(ACTIVE), .ABORT(ABORT), .IRQ_STATUS(IRQ_STATUS)
);

// file: verif/ibm_command_tb.sv
// Testbench: command window, channel control and timing select
`timescale 1ns/10ps
module ibm_command_tb
	import ibm_pkg::*;
;
	localparam logic [15:0]	BA = 16'hFFA0;
	localparam ibm_timing_t	TT [4] = '{6'h2C, 6'h24, 6'h1B, 6'h19};
	logic	clk = 1'b0, srst = 1'b1, sel = 1'b0, wr = 1'b0;
	logic [15:0]	addr = 16'h0000;
	logic [3:0]	be = 4'h0;
	logic [31:0]	wd = 32'h0000_0000;
	logic [1:0]	eot = 2'h0, sync = 2'h0, dcyc = 2'h0, donly = 2'h0;
	ibm_mode_t	fm0 = IBM_MODE_PIO0, fm1 = IBM_MODE_PIO0;
	wire logic [1:0]	irq, go, dir, act, abt, ist;
	wire logic [31:0]	rd;
	wire logic	hit;
	ibm_timing_t	t0, t1;
	int	n_fail = 0, checks = 0, n_abt = 0;
	// timings counted in clocks; clock rate not modelled
	always #25 clk = ~clk;
	always @(posedge clk) if (abt[0] === 1'b1) n_abt++;
	// one timing per channel, slave shares it
	ibm_command ibm_command_inst (
		.CLOCK(clk), .SRST(srst), .BASE_ADDR(BA), .IO_SEL(sel), .IO_WR(wr),
		.IO_ADDR(addr), .IO_BE(be), .IO_WDATA(wd), .EOT_DONE(eot), .SYNC_DMA(sync),
		.DRIVE_IRQ(irq), .DMA_CYCLE(dcyc), .DMA_ONLY_TIMING_ENABLE(donly),
		.FAST_MODE_0(fm0), .FAST_MODE_1(fm1), .IO_RDATA(rd), .IO_HIT(hit),
		.GO(go), .DIRECTION(dir), .ACTIVE(act), .ABORT(abt), .IRQ_STATUS(ist),
		.TIMING_0(t0), .TIMING_1(t1)
	);
	ibm_drive_model ibm_drive_model_inst (.clk(clk), .go(go), .irq(irq));
	task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic test_done;
		if (n_fail == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	// One-cycle strobe; read data is valid on return
	task automatic acc(logic w, logic [15:0] a, logic [3:0] b, logic [31:0] d);
		@(posedge clk);
		#1 {sel, wr, addr, be, wd} = {1'b1, w, BA + a, b, d};
		@(posedge clk);
		#1 sel = 1'b0;
	endtask : acc
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	initial begin
		repeat (16) @(posedge clk);
		#1 srst = 1'b0;
		acc(0, 0, 4'hF, 0);
		cmp("pri", 0, rd);
		acc(0, 8, 4'hF, 0);
		cmp("sec", 0, rd);
		acc(1, 0, 4'h1, 32'h0000_00FF);
		acc(0, 0, 4'hF, 0);
		cmp("pri", 32'h0001_0009, rd);
		cmp("ctl", 'h15, 32'({go, dir, act}));
		acc(1, 8, 4'h3, 32'h0000_FF08);
		acc(0, 8, 4'hF, 0);
		cmp("sec", 32'h0000_0008, rd);
		acc(0, 16, 4'hF, 0);
		cmp("miss", 0, 32'(hit));
		acc(0, 4, 4'hF, 0);
		cmp("gap", 32'h1, {rd[31:1], hit});
		sync = 2'h1;
		acc(1, 0, 4'h1, 32'h0000_0001);
		tick(1);
		cmp("lock", 'h3, 32'(dir));
		sync = 2'h0;
		for (int i = 0; i < 100 && ist[0] !== 1'b1; i++) tick(1);
		cmp("irq", 1, 32'(ist[0]));
		if (ist[0] !== 1'b1) test_done();
		acc(0, 0, 4'hF, 0);
		cmp("pri", 32'h0005_0009, rd);
		acc(1, 0, 4'h1, 32'h0000_0008);
		acc(1, 0, 4'h5, 32'h0004_0008);
		acc(0, 0, 4'hF, 0);
		cmp("pri", 32'h0000_0008, rd);
		acc(1, 0, 4'h1, 32'h0000_0001);
		acc(1, 0, 4'h1, 32'h0000_0000);
		tick(3);
		cmp("abort", 1, n_abt);
		acc(1, 8, 4'h1, 32'h0000_0009);
		eot = 2'h2;
		tick(1);
		eot = 2'h0;
		tick(2);
		cmp("ctl", 'h08, 32'({go, dir, act}));
		acc(0, 8, 4'hF, 0);
		cmp("sec", 32'h0000_0009, rd);
		for (int m = 0; m < 4; m++) begin
			fm0 = ibm_mode_t'(m);
			fm1 = ibm_mode_t'(3 - m);
			tick(2);
			cmp("tim", 32'(TT[m]), 32'(t0));
			cmp("tim1", 32'(TT[3 - m]), 32'(t1));
		end
		donly = 2'h1;
		tick(2);
		cmp("pio", 32'(TT[0]), 32'(t0));
		dcyc = 2'h1;
		tick(2);
		cmp("dma", 32'(TT[3]), 32'(t0));
		srst = 1'b1;
		tick(2);
		srst = 1'b0;
		acc(0, 8, 4'hF, 0);
		cmp("rst", 0, rd);
		test_done();
	end
endmodule : ibm_command_tb
